// *** design/frc_fault_ctrl.sv ***
// Input over-voltage fault response and restart controller.
module frc_fault_ctrl
    import frc_pkg::*;
#(
    parameter int unsigned UNIT_W = UNIT_W_DEF
)
(
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Fault response setting write and read back.
    input  wire logic              cfg_wr,
    input  wire logic [CFG_W-1:0]  cfg_wdata,
    output logic [CFG_W-1:0]       cfg_rdata,
    // Delay unit length in clock cycles, from the timing setting.
    input  wire logic [UNIT_W-1:0] unit_cycles,
    // Fault detection from the comparator logic on this clock.
    input  wire logic              fault_det,
    // Clearing and on/off commands.
    input  wire logic              status_clr,
    input  wire logic              clear_faults,
    input  wire logic              ctrl_pin,
    input  wire logic              op_on,
    // Output control and status.
    output logic                   out_en,
    output logic                   fault_status,
    output logic                   fault_latched,
    output logic [2:0]             attempts
);
    import frc_pkg::*;

    initial
    begin
        if (UNIT_W < 1 || UNIT_W > 32)
            $error("frc_fault_ctrl: UNIT_W out of range");
    end

    typedef struct packed {
        frc_state_e       state;
        logic [CFG_W-1:0] cfg;
        logic             out_en;
        logic             status;
        logic             latched;
        logic             trying;
        logic [2:0]       attempts;
    } frc_ctrl_s;

    frc_ctrl_s  q_r;
    frc_ctrl_s  q_nxt;
    logic       ctrl_s;
    logic       on_now;
    logic       clr_any;
    logic       tmr_start;
    logic       tmr_done;
    logic       set_status;
    logic [1:0] resp;
    logic [2:0] retry;
    logic       limit_hit;

    // The control pin is asynchronous to mclk and is synchronised first.
    frc_sync2 u_ctrl_sync
    (
        .mclk (mclk),
        .rst_n(rst_n),
        .din  (ctrl_pin),
        .dout (ctrl_s)
    );

    // One timer serves both the run-on delay and the restart spacing.
    frc_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .start      (tmr_start),
        .exp_n      (q_r.cfg[DELAY_MSB:DELAY_LSB]),
        .unit_cycles(unit_cycles),
        .done       (tmr_done),
        .busy       ()
    );

    // Field decode and the combined on command of pin and command.
    assign resp      = q_r.cfg[RESP_MSB:RESP_LSB];
    assign retry     = q_r.cfg[RETRY_MSB:RETRY_LSB];
    assign on_now    = ctrl_s & op_on;
    assign clr_any   = status_clr | clear_faults;
    assign limit_hit = (retry != RETRY_FOREVER) && (q_r.attempts >= retry);

    // Next-state logic. A fault during a restart attempt keeps the spacing
    // timer running, so the next attempt still starts one period after the last.
    // If the period ends in the very cycle the fault is seen, the timer restarts so
    // the hold-off cannot hang; with a one-cycle period starts are then two apart.
    always_comb
    begin
        q_nxt      = q_r;
        tmr_start  = 1'b0;
        set_status = 1'b0;
        if (cfg_wr)
            q_nxt.cfg = cfg_wdata;
        if (!on_now)
        begin
            // Off stops any retry sequence and prepares the off-then-on clear.
            q_nxt.state    = FRC_RUN;
            q_nxt.out_en   = 1'b0;
            q_nxt.trying   = 1'b0;
            q_nxt.attempts = 3'h0;
        end
        else if (clr_any && (q_r.state == FRC_LATCH || q_r.state == FRC_HOLD))
        begin
            q_nxt.state    = FRC_RUN;
            q_nxt.out_en   = 1'b1;
            q_nxt.trying   = 1'b0;
            q_nxt.attempts = 3'h0;
        end
        else
        begin
            case (q_r.state)
                FRC_RUN:
                begin
                    q_nxt.out_en = 1'b1;
                    if (q_r.trying && tmr_done && !fault_det)
                    begin
                        q_nxt.trying   = 1'b0;
                        q_nxt.attempts = 3'h0;
                    end
                    if (fault_det)
                    begin
                        case (resp)
                            RESP_IGNORE:
                                q_nxt.out_en = 1'b1;
                            RESP_LATCH:
                            begin
                                q_nxt.out_en = 1'b0;
                                q_nxt.state  = FRC_LATCH;
                                set_status   = 1'b1;
                            end
                            RESP_DELAYED:
                            begin
                                if (q_r.trying)
                                begin
                                    q_nxt.out_en = 1'b0;
                                    set_status   = 1'b1;
                                    tmr_start    = tmr_done;
                                    q_nxt.state  = limit_hit ? FRC_LATCH : FRC_HOLD;
                                end
                                else
                                begin
                                    q_nxt.state = FRC_DELAY;
                                    tmr_start   = 1'b1;
                                end
                            end
                            default:
                            begin
                                q_nxt.out_en = 1'b0;
                                set_status   = 1'b1;
                                if (q_r.trying)
                                begin
                                    q_nxt.state = limit_hit ? FRC_LATCH : FRC_HOLD;
                                    tmr_start   = tmr_done;
                                end
                                else if (retry == RETRY_NONE)
                                    q_nxt.state = FRC_LATCH;
                                else
                                begin
                                    q_nxt.state = FRC_HOLD;
                                    tmr_start   = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                FRC_DELAY:
                begin
                    q_nxt.out_en = 1'b1;
                    if (!fault_det)
                        q_nxt.state = FRC_RUN;
                    else if (tmr_done)
                    begin
                        q_nxt.out_en = 1'b0;
                        set_status   = 1'b1;
                        if (retry == RETRY_NONE)
                            q_nxt.state = FRC_LATCH;
                        else
                        begin
                            q_nxt.state = FRC_HOLD;
                            tmr_start   = 1'b1;
                        end
                    end
                end
                FRC_HOLD:
                begin
                    q_nxt.out_en = 1'b0;
                    if (tmr_done)
                    begin
                        // Attempt starts now; the timer marks the next start.
                        q_nxt.state    = FRC_RUN;
                        q_nxt.out_en   = 1'b1;
                        q_nxt.trying   = 1'b1;
                        q_nxt.attempts = (q_r.attempts == 3'h7) ? 3'h7
                                         : q_r.attempts + 3'h1;
                        tmr_start      = 1'b1;
                    end
                end
                FRC_LATCH:
                    q_nxt.out_en = 1'b0;
                default:
                    q_nxt.state = FRC_RUN;
            endcase
        end
        // A fault event in the cycle of a clear keeps the status bit set.
        q_nxt.status = (q_r.status & ~clr_any) | set_status;
        q_nxt.latched = (q_nxt.state == FRC_LATCH); // Registered copy for the pin.
    end

    // Reset returns the setting to default and clears any latched fault.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_r       <= '0;
            q_r.state <= FRC_RUN;
            q_r.cfg   <= CFG_RESET;
        end
        else
            q_r <= q_nxt;
    end

    assign cfg_rdata     = q_r.cfg;
    assign out_en        = q_r.out_en;
    assign fault_status  = q_r.status;
    assign fault_latched = q_r.latched;
    assign attempts      = q_r.attempts;

    a_ignore_keeps_on: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_RUN && on_now && resp == RESP_IGNORE && fault_det && !clr_any)
        |=> q_r.out_en && !$rose(q_r.status) ##1 q_r.out_en || !on_now || cfg_wr)
        else $error("Ignored fault changed the output.");

    a_delay_keeps_on: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_DELAY && on_now && fault_det && !tmr_done)
        |=> q_r.out_en && q_r.state == FRC_DELAY)
        else $error("Output dropped before the run-on delay ended.");

    a_disable_now: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_RUN && on_now && fault_det && resp == RESP_RETRY)
        |=> !q_r.out_en && q_r.status)
        else $error("Output not disabled on a disable-and-retry fault.");

    a_latch_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_LATCH && on_now && !clr_any)
        |=> q_r.state == FRC_LATCH && !q_r.out_en)
        else $error("Latched fault left without a clearing event.");

    a_clear_unlatches: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_LATCH && on_now && clr_any)
        |=> q_r.state == FRC_RUN && q_r.out_en)
        else $error("Clear command did not release the latched fault.");

    a_off_unlatches: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_LATCH && !on_now) |=> q_r.state == FRC_RUN && !q_r.out_en)
        else $error("Off command did not release the latched fault.");

    a_no_retry_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_RUN && on_now && fault_det && resp == RESP_RETRY
         && !q_r.trying && retry == RETRY_NONE) |=> q_r.state == FRC_LATCH)
        else $error("Retry setting 000 did not latch off.");

    a_limit_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_RUN && on_now && fault_det && resp == RESP_RETRY
         && q_r.trying && limit_hit) |=> q_r.state == FRC_LATCH)
        else $error("Failed final attempt did not latch off.");

    a_unlimited_retry: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_RUN && on_now && fault_det && resp == RESP_RETRY
         && retry == RETRY_FOREVER) |=> q_r.state == FRC_HOLD)
        else $error("Unlimited retry setting latched off.");

    a_attempt_count: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_HOLD && on_now && tmr_done && !clr_any && q_r.attempts < 3'h7)
        |=> q_r.attempts == $past(q_r.attempts) + 3'h1 && q_r.out_en && q_r.trying)
        else $error("Restart attempt was not counted.");

    a_success_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.state == FRC_RUN && on_now && q_r.trying && tmr_done && !fault_det)
        |=> q_r.attempts == 3'h0 && !q_r.trying)
        else $error("Attempt counter kept after a successful restart.");

endmodule : frc_fault_ctrl

// *** design/frc_pkg.sv ***
// Shared constants and types for the input over-voltage fault response controller.
package frc_pkg;

    // Fault response setting layout.
    localparam int unsigned CFG_W        = 8;
    localparam int unsigned RESP_MSB     = 7;
    localparam int unsigned RESP_LSB     = 6;
    localparam int unsigned RETRY_MSB    = 5;
    localparam int unsigned RETRY_LSB    = 3;
    localparam int unsigned DELAY_MSB    = 2;
    localparam int unsigned DELAY_LSB    = 0;
    localparam logic [7:0]  CFG_RESET    = 8'h80;

    // Response field codes.
    localparam logic [1:0]  RESP_IGNORE  = 2'h0;
    localparam logic [1:0]  RESP_DELAYED = 2'h1;
    localparam logic [1:0]  RESP_RETRY   = 2'h2;
    localparam logic [1:0]  RESP_LATCH   = 2'h3;

    // Retry field codes.
    localparam logic [2:0]  RETRY_NONE   = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER = 3'h7;

    // Delay unit counter width; a unit of zero is served as one cycle.
    localparam int unsigned UNIT_W_DEF   = 16;
    localparam logic [7:0]  UNITS_ONE    = 8'h01;

    // Controller states, Gray coded along run, delay, hold-off, latched.
    typedef enum logic [1:0] {
        FRC_RUN   = 2'b00,
        FRC_DELAY = 2'b01,
        FRC_HOLD  = 2'b11,
        FRC_LATCH = 2'b10
    } frc_state_e;

endpackage : frc_pkg

// *** design/frc_sync2.sv ***
// Two flip-flop synchroniser for a level arriving from a pin.
module frc_sync2
(
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_n,
    // Level in and synchronised level out.
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } frc_sync_s;

    frc_sync_s q_r;
    frc_sync_s q_nxt;

    // The first stage feeds only the second stage.
    always_comb
    begin
        q_nxt    = q_r;
        q_nxt.s1 = din;
        q_nxt.s2 = q_r.s1;
    end

    // Both stages start low so the control pin reads as off after reset.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    assign dout = q_r.s2;

endmodule : frc_sync2

// *** design/frc_delay_timer.sv ***
// Delay timer: counts 2**n delay units, each a programmable number of clock cycles.
module frc_delay_timer
    import frc_pkg::*;
#(
    parameter int unsigned UNIT_W = UNIT_W_DEF
)
(
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Control.
    input  wire logic              start,
    input  wire logic [2:0]        exp_n,
    input  wire logic [UNIT_W-1:0] unit_cycles,
    // Status.
    output logic                   done,
    output logic                   busy
);
    initial
    begin
        if (UNIT_W < 1 || UNIT_W > 32)
            $error("frc_delay_timer: UNIT_W out of range");
    end

    typedef struct packed {
        logic              busy;
        logic [UNIT_W-1:0] pre;
        logic [7:0]        left;
    } frc_tmr_s;

    frc_tmr_s          q_r;
    frc_tmr_s          q_nxt;
    logic [UNIT_W-1:0] unit_m1;

    // A unit of zero would never end, so it is served as one cycle.
    assign unit_m1 = (unit_cycles == '0) ? '0 : unit_cycles - 1'b1;

    // A start always reloads, so a restart mid-count measures from the new start.
    always_comb
    begin
        q_nxt      = q_r;
        if (start)
        begin
            q_nxt.busy = 1'b1;
            q_nxt.pre  = unit_m1;
            q_nxt.left = (UNITS_ONE << exp_n) - UNITS_ONE;
        end
        else if (q_r.busy)
        begin
            if (q_r.pre != '0)
                q_nxt.pre = q_r.pre - 1'b1;
            else if (q_r.left != 8'h00)
            begin
                q_nxt.left = q_r.left - 8'h01;
                q_nxt.pre  = unit_m1;
            end
            else
                q_nxt.busy = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    // Done is decoded from the count, so the user acts exactly one period after the
    // start edge; a registered flag would stretch every period by a cycle.
    assign done = q_r.busy && (q_r.pre == '0) && (q_r.left == 8'h00);
    assign busy = q_r.busy;

    a_timer_load_units: assert property (@(posedge mclk) disable iff (!rst_n)
        start |=> (q_r.left == (UNITS_ONE << $past(exp_n)) - UNITS_ONE) && q_r.busy)
        else $error("Delay timer did not load 2**n units.");

    a_timer_done_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        (done && !start) |=> !done)
        else $error("Delay timer done lasted more than one cycle.");

endmodule : frc_delay_timer

// *** dv/frc_host.sv ***
// Host model that drives the command inputs of the fault response controller.
module frc_host
(
    // Clock.
    input  wire logic                   mclk,
    // Setting write strobe and data.
    output logic                        cfg_wr,
    output logic [frc_pkg::CFG_W-1:0]   cfg_wdata,
    // Clearing and on/off commands.
    output logic                        status_clr,
    output logic                        clear_faults,
    output logic                        ctrl_pin,
    output logic                        op_on
);
    timeunit 1ns;
    timeprecision 1ps;
    import frc_pkg::*;

    // Everything starts idle with the output commanded off.
    initial
    begin
        cfg_wr       = 1'b0;
        cfg_wdata    = 8'h00;
        status_clr   = 1'b0;
        clear_faults = 1'b0;
        ctrl_pin     = 1'b0;
        op_on        = 1'b0;
    end

    // A setting write is a one-cycle strobe launched just after an edge.
    task automatic write_cfg(input logic [7:0] v);
        @(posedge mclk);
        #2;
        cfg_wr    = 1'b1;
        cfg_wdata = v;
        @(posedge mclk);
        #2;
        cfg_wr    = 1'b0;
        cfg_wdata = ~v; // Stale data is scrambled so nobody can lean on it.
    endtask : write_cfg

    // One clear pulse: the status bit alone, or the clear-all command.
    task automatic clear(input bit all);
        @(posedge mclk);
        #2;
        status_clr   = !all;
        clear_faults = all;
        @(posedge mclk);
        #2;
        status_clr   = 1'b0;
        clear_faults = 1'b0;
    endtask : clear

    // The output is on only while both the pin and the command bit say so.
    task automatic set_on(input logic pin, input logic op);
        @(posedge mclk);
        #2;
        ctrl_pin = pin;
        op_on    = op;
    endtask : set_on
endmodule : frc_host

// *** dv/test_fault_response_retry_ctrl.sv ***
// Self-checking testbench for the fault response and restart controller.
module test_fault_response_retry_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import frc_pkg::*;

    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       fault_det = 1'b0;
    logic [7:0] unit_cycles = 8'h01;
    logic       cfg_wr;
    logic [7:0] cfg_wdata;
    logic [7:0] cfg_rdata;
    logic       status_clr;
    logic       clear_faults;
    logic       ctrl_pin;
    logic       op_on;
    logic       out_en;
    logic       fault_status;
    logic       fault_latched;
    logic [2:0] attempts;
    int         bad_count = 0;
    int         num_checks = 0;

    // A 50 MHz clock.
    always #10 mclk = ~mclk;

    frc_host host (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .status_clr(status_clr), .clear_faults(clear_faults), .ctrl_pin(ctrl_pin),
        .op_on(op_on));

    frc_fault_ctrl #(.UNIT_W(8)) dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .unit_cycles(unit_cycles),
        .fault_det(fault_det), .status_clr(status_clr), .clear_faults(clear_faults),
        .ctrl_pin(ctrl_pin), .op_on(op_on), .out_en(out_en),
        .fault_status(fault_status), .fault_latched(fault_latched), .attempts(attempts));

    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk_val

    // Steps n edges and lands 2 ns after the last one, where inputs change.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : cyc

    // Bounded wait for the output enable (sel 0) or the latch flag (sel 1).
    task automatic wait_on(input bit sel, input logic v, input int lim, input string what);
        int n;
        n = 0;
        while ((sel ? fault_latched : out_en) !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk_bit(sel ? fault_latched : out_en, v, what);
    endtask : wait_on

    // Holds the present fault and counts restarts; gap is the spacing of the last two.
    task automatic run_fault(input int lim, output int rises, output int gap);
        int   last;
        logic prev;
        rises = 0;
        gap   = 0;
        last  = 0;
        prev  = out_en;
        for (int n = 0; n < lim && fault_latched !== 1'b1; n++)
        begin
            cyc(1);
            if (out_en === 1'b1 && prev !== 1'b1)
            begin
                rises++;
                gap  = n - last;
                last = n;
            end
            prev = out_en;
        end
    endtask : run_fault

    // Removes the fault and clears everything so the next test starts running.
    task automatic recover();
        fault_det = 1'b0;
        host.clear(1'b1);
        wait_on(1'b0, 1'b1, 8, "recover");
    endtask : recover

    // A one-cycle fault under the latch-off response.
    task automatic trip_latch();
        fault_det = 1'b1;
        cyc(1);
        fault_det = 1'b0;
        cyc(1);
        chk_bit(fault_latched, 1'b1, "latched");
        chk_bit(out_en, 1'b0, "off at once");
    endtask : trip_latch

    task automatic t_reset_ignore();
        chk_val(cfg_rdata, 8'h80, "setting reset");
        chk_bit(out_en, 1'b0, "off after reset");
        host.set_on(1'b1, 1'b1);
        wait_on(1'b0, 1'b1, 10, "power on");
        host.write_cfg(8'h3f);
        chk_val(cfg_rdata, 8'h3f, "setting readback");
        fault_det = 1'b1;
        cyc(20);
        chk_bit(out_en, 1'b1, "ignored fault");
        chk_bit(fault_status, 1'b0, "ignored status");
        fault_det = 1'b0;
        $display("test reset_ignore done");
    endtask : t_reset_ignore

    task automatic t_latch_clear();
        host.write_cfg({RESP_LATCH, 6'h3f});
        trip_latch();
        cyc(10);
        chk_bit(out_en, 1'b0, "stays off");
        host.clear(1'b0);
        wait_on(1'b0, 1'b1, 4, "status clear");
        chk_bit(fault_status, 1'b0, "status gone");
        trip_latch();
        host.clear(1'b1);
        wait_on(1'b0, 1'b1, 4, "clear all");
        for (int m = 0; m < 2; m++)
        begin
            // Off by the pin first, then by the command bit.
            trip_latch();
            host.set_on(1'(m), 1'(!m));
            cyc(4);
            host.set_on(1'b1, 1'b1);
            wait_on(1'b0, 1'b1, 8, "off then on");
        end
        trip_latch();
        rst_n = 1'b0;
        cyc(2);
        chk_bit(fault_latched, 1'b0, "reset unlatch");
        rst_n = 1'b1;
        wait_on(1'b0, 1'b1, 8, "on after reset");
        $display("test latch_clear done");
    endtask : t_latch_clear

    task automatic t_retries();
        int rises;
        int gap;
        for (int r = 0; r < 6; r++)
        begin
            host.write_cfg({RESP_RETRY, 3'(r), 3'h0});
            fault_det = 1'b1;
            cyc(1);
            chk_bit(out_en, 1'b0, "disable now");
            run_fault(100, rises, gap);
            chk_val(8'(rises), 8'(r), "restart count");
            chk_val({5'h0, attempts}, 8'(r), "attempts");
            chk_bit(fault_latched, 1'b1, "latched at end");
            recover();
            cyc(2);
            chk_val({5'h0, attempts}, 8'h00, "attempts cleared");
        end
        // A fault that goes away during the first attempt counts as a good restart.
        host.write_cfg({RESP_RETRY, 3'h2, 3'h0});
        fault_det = 1'b1;
        for (int n = 0; n < 20 && attempts !== 3'h1; n++)
            cyc(1);
        fault_det = 1'b0;
        cyc(8);
        chk_val({5'h0, attempts}, 8'h00, "restart success");
        chk_bit(out_en, 1'b1, "running again");
        $display("test retries done");
    endtask : t_retries

    task automatic t_spacing();
        int rises;
        int gap;
        for (int k = 0; k < 4; k++)
        begin
            unit_cycles = 8'(2 + k[0]);
            host.write_cfg({RESP_RETRY, 3'h2, 3'(k[1] * 2)});
            fault_det = 1'b1;
            run_fault(400, rises, gap);
            chk_val(8'(gap), 8'((2 + k[0]) * (1 << (k[1] * 2))), "spacing");
            recover();
        end
        $display("test spacing done");
    endtask : t_spacing

    task automatic t_delayed();
        unit_cycles = 8'h02;
        host.write_cfg({RESP_DELAYED, 3'h0, 3'h2});
        fault_det = 1'b1;
        cyc(3);
        fault_det = 1'b0;
        cyc(12);
        chk_bit(out_en, 1'b1, "short fault rides");
        chk_bit(fault_latched, 1'b0, "short fault free");
        fault_det = 1'b1;
        cyc(8);
        chk_bit(out_en, 1'b1, "runs during delay");
        cyc(1);
        chk_bit(fault_latched, 1'b1, "acts after delay");
        chk_bit(out_en, 1'b0, "off after delay");
        recover();
        $display("test delayed done");
    endtask : t_delayed

    task automatic t_forever();
        int rises;
        int gap;
        unit_cycles = 8'h01;
        host.write_cfg({RESP_RETRY, RETRY_FOREVER, 3'h0});
        fault_det = 1'b1;
        run_fault(60, rises, gap);
        chk_bit(rises >= 8, 1'b1, "keeps retrying");
        chk_bit(fault_latched, 1'b0, "never latches");
        host.set_on(1'b0, 1'b1);
        cyc(4);
        chk_bit(out_en, 1'b0, "off command stops");
        chk_val({5'h0, attempts}, 8'h00, "off clears count");
        fault_det = 1'b0;
        host.set_on(1'b1, 1'b1);
        wait_on(1'b0, 1'b1, 8, "on again");
        $display("test forever done");
    endtask : t_forever

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Main sequence: reset for 6 cycles, then the tests in turn.
    initial
    begin
        cyc(6);
        rst_n = 1'b1;
        cyc(1);
        t_reset_ignore();
        t_latch_clear();
        t_retries();
        t_spacing();
        t_delayed();
        t_forever();
        finish_test();
    end

    // The tests take under a thousand cycles; a run twenty times longer has hung.
    initial
    begin
        #400us;
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule : test_fault_response_retry_ctrl
